// ### include/crc_consts.vh
// Constants for the current reference control block
`ifndef CRC_CONSTS_VH
`define CRC_CONSTS_VH

// ********************************
// Register addresses and pages
// ********************************
`define CRC_REG_ADDR        8'hb9
`define CRC_PAGE_CONTROL    8'h00
`define CRC_PAGE_CONFIG     8'h0f

// ********************************
// Control register fields
// ********************************
`define CRC_CTL_DIR_BIT     7
`define CRC_CTL_RANGE_BIT   6
`define CRC_CTL_COUNT_MSB   5
`define CRC_CTL_RESET       8'h00

// ********************************
// Config register fields
// ********************************
`define CRC_CFG_FT_EN_BIT   7
`define CRC_CFG_SEL_MSB     2
`define CRC_CFG_RW_MASK     8'h87
`define CRC_CFG_RESET       8'h00

// ********************************
// Fine-tune and step size constants
// ********************************
`define CRC_NUM_CHANNELS    6
`define CRC_SEL_LAST        3'h5
`define CRC_LOW_STEP_UA     4'h1
`define CRC_HIGH_STEP_UA    4'h8

`endif

// ### rtl/crc_reg8.v
// Eight-bit register with synchronous reset and a per-bit write mask
module crc_reg8 #(
	parameter [7:0] RESET_VAL = 8'h00,
	parameter [7:0] WR_MASK   = 8'hff
) (
	// Clock and reset
	input  wire       sys_clk_i,
	input  wire       srst_i,
	// Write port
	input  wire       wr_en_i,
	input  wire [7:0] wr_data_i,
	// Stored value
	output reg  [7:0] q_o
);

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			q_o <= RESET_VAL;
		end else if (wr_en_i) begin
			q_o <= wr_data_i & WR_MASK;
		end
	end

endmodule

// ### rtl/crc_ft_select.v
// Fine-tune source multiplexer with gating by the enable bit
module crc_ft_select (
	// Clock and reset
	input  wire       sys_clk_i,
	input  wire       srst_i,
	// Selection
	input  wire       ft_enable_i,
	input  wire [2:0] ft_select_i,
	input  wire [5:0] channel_i,
	// Gate for the extra element
	output reg        gate_o,
	output reg        select_valid_o
);

	reg next_gate;
	reg next_valid;

	always @* begin
		next_gate  = 1'b0;
		next_valid = 1'b1;
		case (ft_select_i)
			3'h0: next_gate = channel_i[0];
			3'h1: next_gate = channel_i[1];
			3'h2: next_gate = channel_i[2];
			3'h3: next_gate = channel_i[3];
			3'h4: next_gate = channel_i[4];
			3'h5: next_gate = channel_i[5];
			// Reserved codes select nothing, so the element stays off
			default: next_valid = 1'b0;
		endcase
		if (!ft_enable_i) begin
			next_gate = 1'b0;
		end
	end

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			gate_o         <= 1'b0;
			select_valid_o <= 1'b1;
		end else begin
			gate_o         <= next_gate;
			select_valid_o <= next_valid;
		end
	end

endmodule

// ### rtl/crc_current_reference.v
// Register file and output control of the programmable current reference
`include "crc_consts.vh"

// Function
// R1 - Direction bit 7 of the control register selects source at 0 and sink at 1.
// R2 - Range bit 6 selects the 1 uA step at 0 and the 8 uA step at 1.
// R3 - The six-bit step count sets the magnitude as direction times step size times count.
// R4 - A step count of zero puts the reference into its low power disabled state; the code keeps it enabled while fine_tune_gate_o is high.
// R5 - With fine tune enabled the selected counter array output gates an extra element worth two LSBs.
// R6 - With count bits 1:0 at zero a fully high fine-tune signal equals count bits 1:0 set to 10.
// R7 - Fine tune select codes 000 to 101 pick counter array channels 0 to 5 in order.
// R8 - Software must not use select codes 110 or 111, which are reserved and pick no channel.
// R9 - Config bits 6 to 3 read as zero and ignore writes.
// R10 - The config register sits at the control register address on page 0xf instead of page 0.
// R11 - A nonzero setting makes the reference active and writing zero to the control register turns it off; the code keeps it on while fine_tune_gate_o is high.
// R12 - With fine tune disabled the counter array outputs have no effect and the extra element stays off.
// R13 - Register writes load on the system clock and every register bit resets to zero.
module crc_current_reference (
	// Clock and reset
	input  wire       sys_clk_i,
	input  wire       srst_i,
	// Special function register port
	input  wire [7:0] sfr_addr_i,
	input  wire [7:0] sfr_page_i,
	input  wire       sfr_wr_i,
	input  wire       sfr_rd_i,
	input  wire [7:0] sfr_wdata_i,
	output reg  [7:0] sfr_rdata_o,
	output wire       sfr_hit_o,
	// Counter array channel outputs
	input  wire [5:0] counter_array_output_i,
	// Analog stage controls
	output reg        current_reference_enable_o,
	output reg        sink_o,
	output reg        output_range_select_o,
	output reg  [5:0] current_step_count_o,
	output wire       fine_tune_gate_o,
	output wire       fine_tune_select_valid_o,
	output reg  [6:0] effective_steps_o,
	output reg  [9:0] magnitude_ua_o
);

	// ********************************
	// Address decode
	// ********************************
	wire       addr_match;
	wire       sel_control;
	wire       sel_config;
	wire [7:0] control_q;
	wire [7:0] config_q;
	wire [5:0] ch_sync;

	assign addr_match  = (sfr_addr_i == `CRC_REG_ADDR);
	assign sel_control = addr_match && (sfr_page_i == `CRC_PAGE_CONTROL);        // see R10
	assign sel_config  = addr_match && (sfr_page_i == `CRC_PAGE_CONFIG);         // see R10
	assign sfr_hit_o   = sel_control || sel_config;

	// ********************************
	// Registers
	// ********************************
	crc_reg8 #(
		.RESET_VAL (`CRC_CTL_RESET),
		.WR_MASK   (8'hff)
	) u_control (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.wr_en_i   (sfr_wr_i && sel_control),                               // see R13
		.wr_data_i (sfr_wdata_i),
		.q_o       (control_q)
	);

	// Unused config bits are masked on write so they always read as zero
	crc_reg8 #(
		.RESET_VAL (`CRC_CFG_RESET),
		.WR_MASK   (`CRC_CFG_RW_MASK)
	) u_config (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.wr_en_i   (sfr_wr_i && sel_config),                                // see R9
		.wr_data_i (sfr_wdata_i),
		.q_o       (config_q)
	);

	// Read data registered; unmapped reads return zero
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_rd_i && sel_control) begin
			sfr_rdata_o <= control_q;
		end else if (sfr_rd_i && sel_config) begin
			sfr_rdata_o <= config_q;                                         // see R9
		end else begin
			sfr_rdata_o <= 8'h00;
		end
	end

	// ********************************
	// Counter array channel synchronisers
	// ********************************
	// PWM channels may come from another clock, so each passes three stages
	reg [5:0] ch_s1;
	reg [5:0] ch_s2;
	reg [5:0] ch_s3;
	reg [5:0] ch_stable;

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			ch_s1     <= 6'h00;
			ch_s2     <= 6'h00;
			ch_s3     <= 6'h00;
			ch_stable <= 6'h00;
		end else begin
			ch_s1     <= counter_array_output_i;
			ch_s2     <= ch_s1;
			ch_s3     <= ch_s2;
			// Take the new level only where the second and third stages agree, else hold
			ch_stable <= (ch_stable & (ch_s2 ^ ch_s3)) | (ch_s2 & ~(ch_s2 ^ ch_s3));
		end
	end
	assign ch_sync = ch_stable;

	// ********************************
	// Fine-tune source
	// ********************************
	crc_ft_select u_ft_select (
		.sys_clk_i      (sys_clk_i),
		.srst_i         (srst_i),
		.ft_enable_i    (config_q[`CRC_CFG_FT_EN_BIT]),                      // see R5
		.ft_select_i    (config_q[`CRC_CFG_SEL_MSB:0]),                      // see R7
		.channel_i      (ch_sync),
		.gate_o         (fine_tune_gate_o),                                  // see R12
		.select_valid_o (fine_tune_select_valid_o)                           // see R8
	);

	// ********************************
	// Analog stage controls
	// ********************************
	reg [5:0] count_now;
	reg [6:0] next_steps;
	reg [9:0] next_mag;
	reg       next_enable;

	always @* begin
		count_now   = control_q[`CRC_CTL_COUNT_MSB:0];                       // see R3
		// Gated element adds two LSBs, so full duty on 00 equals 10
		next_steps  = {1'b0, count_now} + {5'h00, fine_tune_gate_o, 1'b0};   // see R5, R6
		if (control_q[`CRC_CTL_RANGE_BIT]) begin
			next_mag = {next_steps, 3'h0};                                   // see R2
		end else begin
			next_mag = {3'h0, next_steps};                                   // see R2
		end
		// Zero count means low power state unless the fine-tune gate is high
		next_enable = (count_now != 6'h00) || fine_tune_gate_o;              // see R4, R11
		if (!next_enable) begin
			next_steps = 7'h00;
			next_mag   = 10'h000;
		end
	end

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			current_reference_enable_o <= 1'b0;
			sink_o                     <= 1'b0;
			output_range_select_o      <= 1'b0;
			current_step_count_o       <= 6'h00;
			effective_steps_o          <= 7'h00;
			magnitude_ua_o             <= 10'h000;
		end else begin
			current_reference_enable_o <= next_enable;                       // see R4, R11
			sink_o                     <= control_q[`CRC_CTL_DIR_BIT];      // see R1
			output_range_select_o      <= control_q[`CRC_CTL_RANGE_BIT];    // see R2
			current_step_count_o       <= count_now;                         // see R3
			effective_steps_o          <= next_steps;
			magnitude_ua_o             <= next_mag;
		end
	end

endmodule

// ### verification/crc_monitor.sv
// Assertion checker for the current reference control block
module crc_monitor (
	// Clock and reset
	input wire logic       sys_clk_i,
	input wire logic       srst_i,
	// Register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_page_i,
	input wire logic       sfr_wr_i,
	input wire logic       sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       sfr_hit_o,
	// Channels and analog controls
	input wire logic [5:0] counter_array_output_i,
	input wire logic       current_reference_enable_o,
	input wire logic       sink_o,
	input wire logic       output_range_select_o,
	input wire logic [5:0] current_step_count_o,
	input wire logic       fine_tune_gate_o,
	input wire logic       fine_tune_select_valid_o,
	input wire logic [6:0] effective_steps_o,
	input wire logic [9:0] magnitude_ua_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	wire ctl = sfr_wr_i && sfr_hit_o && sfr_page_i == 8'h00;
	property p_ctl; ctl |-> ##2 {sink_o, output_range_select_o, current_step_count_o} == $past(sfr_wdata_i, 2);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control fields wrong");
	property p_stp; effective_steps_o == {1'b0, current_step_count_o} + ($past(fine_tune_gate_o) ? 7'h02 : 7'h00);
	endproperty
	a_stp: assert property (p_stp) else $error("steps wrong");
	// Magnitude loads on the same edge as the steps, and only settled values are compared
	property p_mag; $stable(effective_steps_o) && $stable(output_range_select_o) |->
		magnitude_ua_o == (output_range_select_o ? {effective_steps_o, 3'h0} : {3'h0, effective_steps_o}); endproperty
	a_mag: assert property (p_mag) else $error("magnitude wrong");
	property p_off; (current_step_count_o == 6'h00 && !fine_tune_gate_o) [*3] |-> !current_reference_enable_o;
	endproperty
	a_off: assert property (p_off) else $error("not disabled");
	property p_on; current_step_count_o != 6'h00 |-> current_reference_enable_o; endproperty
	a_on: assert property (p_on) else $error("not active");
	property p_cfg; sfr_rd_i && sfr_hit_o && sfr_page_i == 8'h0f |=> sfr_rdata_o[6:3] == 4'h0; endproperty
	a_cfg: assert property (p_cfg) else $error("unused bits read");
	property p_hit; sfr_hit_o == (sfr_addr_i == 8'hb9 && (sfr_page_i == 8'h00 || sfr_page_i == 8'h0f)); endproperty
	a_hit: assert property (p_hit) else $error("decode wrong");
	property p_miss; sfr_rd_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00; endproperty
	a_miss: assert property (p_miss) else $error("miss read data");
endmodule
bind crc_current_reference crc_monitor crc_monitor_inst (.*);

// ### verification/crc_pwm_model.sv
// Behavioural counter array channel outputs
module crc_pwm_model (
	// Clock
	input  wire logic       sys_clk_i,
	// Levels commanded by the bench
	input  wire logic [5:0] level_i,
	// Channel outputs
	output var  logic [5:0] counter_array_output_o
);
	// Registered like real channel outputs, so they only move after an edge
	initial counter_array_output_o = 6'h00;
	always @(posedge sys_clk_i) counter_array_output_o <= level_i;
endmodule

// ### verification/crc_current_reference_tb_top.sv
// Self-checking testbench for the current reference control block
module crc_current_reference_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk_i, srst_i, sfr_wr_i, sfr_rd_i, sfr_hit_o, fine_tune_gate_o, fine_tune_select_valid_o;
	logic       current_reference_enable_o, sink_o, output_range_select_o;
	logic [5:0] counter_array_output_i, current_step_count_o, lvl;
	logic [7:0] sfr_addr_i, sfr_page_i, sfr_wdata_i, sfr_rdata_o;
	logic [6:0] effective_steps_o;
	logic [9:0] magnitude_ua_o;
	int         errors = 0, n_compared = 0;
	crc_current_reference crc_current_reference_inst (.*);
	crc_pwm_model crc_pwm_model_inst (.sys_clk_i(sys_clk_i), .level_i(lvl), .counter_array_output_o(counter_array_output_i));
	// ********************************
	// Shared tasks
	// ********************************
	task chk(input logic [9:0] seen, input logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] pg, input logic [7:0] d);
		@(posedge sys_clk_i) #1;
		{sfr_page_i, sfr_wdata_i, sfr_wr_i} = {pg, d, 1'b1};
		@(posedge sys_clk_i) #1;
		sfr_wr_i = 0;
	endtask
	task rd(input logic [7:0] pg, input logic [7:0] e);
		@(posedge sys_clk_i) #1;
		{sfr_page_i, sfr_rd_i} = {pg, 1'b1};
		@(posedge sys_clk_i) #1;
		sfr_rd_i = 0;
		chk(sfr_rdata_o, e);
	endtask
	task stop_test;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task t_ctl;
		logic [7:0] v [0:5] = '{8'h3f, 8'hc1, 8'h7f, 8'h40, 8'h82, 8'h00};
		for (int i = 0; i < 6; i++) begin
			wr(8'h00, v[i]);
			// Analog controls follow the register one cycle after it loads
			@(posedge sys_clk_i) #1;
			chk({sink_o, output_range_select_o, current_step_count_o}, v[i]);
			chk(magnitude_ua_o, v[i][6] ? v[i][5:0] * 8 : v[i][5:0]);
			chk(current_reference_enable_o, v[i][5:0] != 6'h00);
			rd(8'h00, v[i]);
		end
	endtask
	task t_cfg;
		wr(8'h0f, 8'hff);
		rd(8'h0f, 8'h87);
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		sfr_addr_i = 8'hba;
		rd(8'h0f, 8'h00);
		sfr_addr_i = 8'hb9;
	endtask
	task t_ft;
		for (int s = 0; s < 9; s++) begin
			for (int k = 0; k < 2; k++) begin
				lvl = (s < 6) ? 6'h01 << s : 6'h3f;
				if (k) lvl = ~lvl;
				wr(8'h0f, {s < 8, 4'h0, 3'(s)});
				repeat (8) @(posedge sys_clk_i);
				#1;
				chk(fine_tune_gate_o, s < 6 && !k);
				chk(fine_tune_select_valid_o, s != 6 && s != 7);
				chk(magnitude_ua_o, (s < 6 && !k) ? 10'h002 : 10'h000);
			end
		end
	endtask
	initial begin
		sys_clk_i = 0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		{srst_i, sfr_wr_i, sfr_rd_i, lvl} = {3'b100, 6'h00};
		{sfr_addr_i, sfr_page_i, sfr_wdata_i} = {8'hb9, 16'h0000};
		repeat (12) @(posedge sys_clk_i);
		#1;
		srst_i = 0;
		rd(8'h00, 8'h00);
		rd(8'h0f, 8'h00);
		t_ctl;
		t_cfg;
		t_ft;
		stop_test;
	end
	// Whole run is well under a thousand cycles
	initial begin
		#200000;
		errors++;
		stop_test;
	end
endmodule
